// *** rtl/elc_pkg.sv ***
// Constants shared by the exposure loop configuration block
//
// Contract
// RULE1: Freeze bit holds the loop averaging filter and the applied gains unchanged.
// RULE2: Subsample bit clear uses every pixel, set uses every fourth pixel.
// RULE3: Stage order bit set (reset) raises stage one first, clear prefers stage two.
// RULE4: Red contributions weighted by a 3.7 unsigned factor, reset 0x80 meaning unity.
// RULE5: First and second green contributions each have their own 3.7 factor.
// RULE6: Blue contributions weighted by their own 3.7 factor, reset to unity.
// RULE7: Loop never drives digital gain above the programmed 5.7 upper bound.
// RULE8: Loop adjusts only when enabled; restart write reloads filter with target level.
`default_nettype none
package elc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int PIX_W  = 10;
    localparam int WGT_W  = 10;
    localparam int DG_W   = 12;
    localparam int STG_W  = 2;
    localparam int COL_W  = 2;
    localparam int CTRL_W = 5;

    // Register addresses
    localparam logic [7:0] A_CTRL   = 8'ha0;
    localparam logic [7:0] A_TARGET = 8'ha1;
    localparam logic [7:0] A_RED    = 8'ha2;
    localparam logic [7:0] A_GRN1   = 8'ha3;
    localparam logic [7:0] A_GRN2   = 8'ha4;
    localparam logic [7:0] A_BLUE   = 8'ha5;
    localparam logic [7:0] A_SPARE  = 8'ha6;

    // Reset values and the fixed spare register read value
    localparam logic [4:0]  CTRL_RST   = 5'h10;
    localparam logic [15:0] TARGET_RST = 16'h60b8;
    localparam logic [9:0]  WGT_RST    = 10'h080;
    localparam logic [15:0] SPARE_VAL  = 16'h03ff;

    // Control field positions
    localparam int B_EN      = 0;
    localparam int B_RESTART = 1;
    localparam int B_FREEZE  = 2;
    localparam int B_SUB     = 3;
    localparam int B_AMPPRI  = 4;

    // Colour channel codes
    localparam logic [1:0] COL_RED  = 2'h0;
    localparam logic [1:0] COL_GRN1 = 2'h1;
    localparam logic [1:0] COL_GRN2 = 2'h2;
    localparam logic [1:0] COL_BLUE = 2'h3;

    localparam int          FRAC_W     = 7;
    localparam int          FILT_SHIFT = 4;
    localparam logic [1:0]  SUB_LAST   = 2'h3;
    localparam logic [1:0]  STG_STEP   = 2'h1;
    localparam logic [1:0]  STG_MIN    = 2'h0;
    localparam logic [9:0]  PIX_MAX    = 10'h3ff;
    localparam logic [11:0] DG_UNITY   = 12'h080;
    localparam logic [11:0] DG_STEP    = 12'h001;

    // Scales a pixel by a 3.7 factor and saturates to the pixel range
    function automatic logic [9:0] weigh(input logic [9:0] pix, input logic [9:0] w);
        logic [19:0] prod;
        logic [12:0] shifted;
        prod    = pix * w;
        shifted = prod[19:FRAC_W];
        return (|shifted[12:10]) ? PIX_MAX : shifted[9:0];
    endfunction : weigh
endpackage : elc_pkg
`default_nettype wire

// *** rtl/elc_stat_if.sv ***
// Pixel path between subsampler and channel weighting stage
`timescale 1ns/1ps
`default_nettype none
interface elc_stat_if;
    logic       pix_valid;
    logic [1:0] pix_color;
    logic [9:0] pix_data;
    logic       wgt_valid;
    logic [9:0] wgt_data;

    modport src (output pix_valid, output pix_color, output pix_data,
                 input wgt_valid, input wgt_data);
    modport wgt (input pix_valid, input pix_color, input pix_data,
                 output wgt_valid, output wgt_data);
endinterface : elc_stat_if
`default_nettype wire

// *** rtl/elc_weight.sv ***
// Per-colour weighting of accepted pixels for the exposure statistics
`timescale 1ns/1ps
`default_nettype none
module elc_weight (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [9:0] red_weight,
    input  wire logic [9:0] grn1_weight,
    input  wire logic [9:0] grn2_weight,
    input  wire logic [9:0] blue_weight,
    elc_stat_if.wgt         st
);
    wire logic [9:0] sel_weight;

    assign sel_weight = (st.pix_color == elc_pkg::COL_RED)  ? red_weight  :
                        (st.pix_color == elc_pkg::COL_GRN1) ? grn1_weight :
                        (st.pix_color == elc_pkg::COL_GRN2) ? grn2_weight :
                        blue_weight;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st.wgt_valid <= 1'b0;
            st.wgt_data  <= '0;
        end else begin
            st.wgt_valid <= st.pix_valid;
            if (st.pix_valid) begin
                st.wgt_data <= elc_pkg::weigh(st.pix_data, sel_weight); // RULE4 RULE5 RULE6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_red_weight;
        st.pix_valid && st.pix_color == elc_pkg::COL_RED |=>
            st.wgt_valid && st.wgt_data == elc_pkg::weigh($past(st.pix_data), $past(red_weight));
    endproperty
    a_red_weight: assert property (p_red_weight) else $error("red weighting wrong"); // RULE4

    property p_green_weight;
        st.pix_valid && st.pix_color == elc_pkg::COL_GRN1 ##1
        st.pix_valid && st.pix_color == elc_pkg::COL_GRN2 |=>
            st.wgt_data == elc_pkg::weigh($past(st.pix_data), $past(grn2_weight)) &&
            $past(st.wgt_data) == elc_pkg::weigh($past(st.pix_data, 2), $past(grn1_weight, 2));
    endproperty
    a_green_weight: assert property (p_green_weight) else $error("green weighting wrong"); // RULE5

    property p_blue_weight;
        st.pix_valid && st.pix_color == elc_pkg::COL_BLUE |=>
            st.wgt_data == elc_pkg::weigh($past(st.pix_data), $past(blue_weight));
    endproperty
    a_blue_weight: assert property (p_blue_weight) else $error("blue weighting wrong"); // RULE6
endmodule : elc_weight
`default_nettype wire

// *** rtl/elc_regs.sv ***
// Exposure loop configuration registers with the loop filter and gain stepper
`timescale 1ns/1ps
`default_nettype none
module elc_regs (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        pix_valid,
    input  wire logic [1:0]  pix_color,
    input  wire logic [9:0]  pix_data,
    input  wire logic        frame_end,
    input  wire logic [1:0]  max_gain_stage1,
    input  wire logic [1:0]  max_gain_stage2,
    input  wire logic [11:0] max_digital_gain,
    output logic      [1:0]  gain_stage1,
    output logic      [1:0]  gain_stage2,
    output logic      [11:0] digital_gain,
    output logic      [9:0]  filtered_level
);
    logic [4:0]  ctrl;
    logic [15:0] target;
    logic [9:0]  red_weight;
    logic [9:0]  grn1_weight;
    logic [9:0]  grn2_weight;
    logic [9:0]  blue_weight;
    logic [1:0]  sub_cnt [4];

    elc_stat_if st ();

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire logic wr_ctrl   = reg_wr && reg_addr == elc_pkg::A_CTRL;
    wire logic wr_target = reg_wr && reg_addr == elc_pkg::A_TARGET;
    wire logic wr_red    = reg_wr && reg_addr == elc_pkg::A_RED;
    wire logic wr_grn1   = reg_wr && reg_addr == elc_pkg::A_GRN1;
    wire logic wr_grn2   = reg_wr && reg_addr == elc_pkg::A_GRN2;
    wire logic wr_blue   = reg_wr && reg_addr == elc_pkg::A_BLUE;

    wire logic restart_evt = wr_ctrl && reg_wdata[elc_pkg::B_RESTART];
    wire logic en          = ctrl[elc_pkg::B_EN];
    wire logic frz         = ctrl[elc_pkg::B_FREEZE];
    wire logic subsample   = ctrl[elc_pkg::B_SUB];
    wire logic pri         = ctrl[elc_pkg::B_AMPPRI];

    wire logic [15:0] rd_val =
        (reg_addr == elc_pkg::A_CTRL)   ? {11'h000, ctrl}        :
        (reg_addr == elc_pkg::A_TARGET) ? target                 :
        (reg_addr == elc_pkg::A_RED)    ? {6'h00, red_weight}    :
        (reg_addr == elc_pkg::A_GRN1)   ? {6'h00, grn1_weight}   :
        (reg_addr == elc_pkg::A_GRN2)   ? {6'h00, grn2_weight}   :
        (reg_addr == elc_pkg::A_BLUE)   ? {6'h00, blue_weight}   :
        (reg_addr == elc_pkg::A_SPARE)  ? elc_pkg::SPARE_VAL     :
        16'h0000;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl        <= elc_pkg::CTRL_RST; // RULE3
            target      <= elc_pkg::TARGET_RST;
            red_weight  <= elc_pkg::WGT_RST; // RULE4
            grn1_weight <= elc_pkg::WGT_RST; // RULE5
            grn2_weight <= elc_pkg::WGT_RST; // RULE5
            blue_weight <= elc_pkg::WGT_RST; // RULE6
            reg_rdata   <= '0;
        end else begin
            if (wr_ctrl)   ctrl        <= reg_wdata[4:0];
            if (wr_target) target      <= reg_wdata;
            if (wr_red)    red_weight  <= reg_wdata[9:0];
            if (wr_grn1)   grn1_weight <= reg_wdata[9:0];
            if (wr_grn2)   grn2_weight <= reg_wdata[9:0];
            if (wr_blue)   blue_weight <= reg_wdata[9:0];
            if (reg_rd)    reg_rdata   <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Subsampling: per-colour phase counter picks one pixel in four
    wire logic sub_hit = sub_cnt[pix_color] == elc_pkg::SUB_LAST;

    assign st.pix_valid = pix_valid && (!subsample || sub_hit); // RULE2
    assign st.pix_color = pix_color;
    assign st.pix_data  = pix_data;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                sub_cnt[i] <= '0;
            end
        end else if (pix_valid) begin
            sub_cnt[pix_color] <= sub_cnt[pix_color] + elc_pkg::STG_STEP; // RULE2
        end
    end

    elc_weight u_weight (
        .mclk        (mclk),
        .nrst        (nrst),
        .red_weight  (red_weight),
        .grn1_weight (grn1_weight),
        .grn2_weight (grn2_weight),
        .blue_weight (blue_weight),
        .st          (st.wgt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Averaging filter: first-order low pass of weighted samples
    wire logic signed [10:0] diff = signed'({1'b0, st.wgt_data}) - signed'({1'b0, filtered_level});
    wire logic signed [10:0] step = diff >>> elc_pkg::FILT_SHIFT;
    wire logic [9:0] next_level   = filtered_level + step[9:0];

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            filtered_level <= elc_pkg::TARGET_RST[9:0];
        end else if (restart_evt) begin
            filtered_level <= target[9:0]; // RULE8
        end else if (st.wgt_valid && en && !frz) begin
            filtered_level <= next_level; // RULE1 RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gain stepper, one step per frame
    wire logic adjust = frame_end && en && !frz; // RULE1 RULE8
    wire logic raise  = adjust && filtered_level < target[9:0];
    wire logic lower  = adjust && filtered_level > target[9:0];

    wire logic s1_can_up = gain_stage1 < max_gain_stage1;
    wire logic s2_can_up = gain_stage2 < max_gain_stage2;
    wire logic dg_can_up = {1'b0, digital_gain} + {1'b0, elc_pkg::DG_STEP} <=
                           {1'b0, max_digital_gain};
    wire logic dg_can_dn = digital_gain > elc_pkg::DG_UNITY;
    wire logic s1_zero   = gain_stage1 == elc_pkg::STG_MIN;
    wire logic s2_zero   = gain_stage2 == elc_pkg::STG_MIN;

    wire logic up_s1 = raise && s1_can_up && (pri || !s2_can_up); // RULE3
    wire logic up_s2 = raise && s2_can_up && (!pri || !s1_can_up); // RULE3
    wire logic up_dg = raise && !s1_can_up && !s2_can_up && dg_can_up; // RULE7
    wire logic dn_dg = lower && dg_can_dn;
    wire logic dn_s2 = lower && !dg_can_dn && !s2_zero && (pri || s1_zero); // RULE3
    wire logic dn_s1 = lower && !dg_can_dn && !s1_zero && (!pri || s2_zero); // RULE3
    wire logic dg_over = adjust && digital_gain > max_digital_gain;

    wire logic [11:0] next_dg =
        dg_over ? max_digital_gain : // RULE7
        up_dg   ? digital_gain + elc_pkg::DG_STEP :
        dn_dg   ? digital_gain - elc_pkg::DG_STEP :
        digital_gain;
    wire logic [1:0] next_s1 = up_s1 ? gain_stage1 + elc_pkg::STG_STEP :
                               dn_s1 ? gain_stage1 - elc_pkg::STG_STEP : gain_stage1;
    wire logic [1:0] next_s2 = up_s2 ? gain_stage2 + elc_pkg::STG_STEP :
                               dn_s2 ? gain_stage2 - elc_pkg::STG_STEP : gain_stage2;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gain_stage1  <= elc_pkg::STG_MIN;
            gain_stage2  <= elc_pkg::STG_MIN;
            digital_gain <= elc_pkg::DG_UNITY;
        end else begin
            gain_stage1  <= next_s1;
            gain_stage2  <= next_s2;
            digital_gain <= next_dg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_freeze_hold;
        frz && frame_end && !wr_ctrl |=>
            $stable(gain_stage1) && $stable(gain_stage2) && $stable(digital_gain);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("gains moved while frozen"); // RULE1

    property p_freeze_filter;
        frz && !restart_evt ##1 frz && !restart_evt |-> $stable(filtered_level);
    endproperty
    a_freeze_filter: assert property (p_freeze_filter) else $error("filter moved while frozen"); // RULE1

    property p_sub_skip;
        pix_valid && subsample && sub_cnt[pix_color] != elc_pkg::SUB_LAST |=> !st.wgt_valid;
    endproperty
    a_sub_skip: assert property (p_sub_skip) else $error("subsampled pixel not skipped"); // RULE2

    property p_full_take;
        pix_valid && !subsample |=> st.wgt_valid;
    endproperty
    a_full_take: assert property (p_full_take) else $error("pixel dropped without subsampling"); // RULE2

    property p_stage_order;
        raise && s1_can_up && s2_can_up |=>
            ($past(pri) ? (gain_stage1 == $past(gain_stage1) + elc_pkg::STG_STEP &&
                           $stable(gain_stage2))
                 : (gain_stage2 == $past(gain_stage2) + elc_pkg::STG_STEP && $stable(gain_stage1)));
    endproperty
    a_stage_order: assert property (p_stage_order) else $error("wrong stage raised"); // RULE3

    property p_dg_bound;
        adjust |=> digital_gain <= $past(max_digital_gain);
    endproperty
    a_dg_bound: assert property (p_dg_bound) else $error("digital gain above bound"); // RULE7

    property p_restart;
        restart_evt |=> filtered_level == $past(target[9:0]);
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not load target"); // RULE8

    property p_disabled_hold;
        !en && !wr_ctrl |=> $stable(gain_stage1) && $stable(gain_stage2) && $stable(digital_gain);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("gains moved while disabled"); // RULE8

    c_restart:   cover property (restart_evt ##1 st.wgt_valid);
    c_dg_raise:  cover property (up_dg);
    c_sub_take:  cover property (pix_valid && subsample && sub_hit);
    c_freeze_fe: cover property (frz && frame_end && en);
endmodule : elc_regs
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the exposure loop configuration registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk = 1'b0;
    logic        nrst;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        pix_valid;
    logic [1:0]  pix_color;
    logic [9:0]  pix_data;
    logic        frame_end;
    logic [1:0]  max_gain_stage1;
    logic [1:0]  max_gain_stage2;
    logic [11:0] max_digital_gain;
    logic [1:0]  gain_stage1;
    logic [1:0]  gain_stage2;
    logic [11:0] digital_gain;
    logic [9:0]  filtered_level;
    logic [9:0]  lvl;
    int          n_errors;
    int          checks;

    elc_regs elc_regs_i (
        .mclk             (mclk),
        .nrst             (nrst),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .pix_valid        (pix_valid),
        .pix_color        (pix_color),
        .pix_data         (pix_data),
        .frame_end        (frame_end),
        .max_gain_stage1  (max_gain_stage1),
        .max_gain_stage2  (max_gain_stage2),
        .max_digital_gain (max_digital_gain),
        .gain_stage1      (gain_stage1),
        .gain_stage2      (gain_stage2),
        .digital_gain     (digital_gain),
        .filtered_level   (filtered_level)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check

    // Bus tasks start and end just after a falling edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        // Let an edge pass so back-to-back writes never glitch the strobe
        @(negedge mclk);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
        check(reg_rdata, exp);
    endtask : rdchk

    task automatic pix(input logic [1:0] c, input logic [9:0] d);
        pix_color = c;
        pix_data  = d;
        pix_valid = 1'b1;
        @(negedge mclk);
        pix_valid = 1'b0;
        repeat (2) @(negedge mclk);
    endtask : pix

    task automatic fend(input logic [1:0] s1, input logic [1:0] s2, input logic [11:0] dg);
        frame_end = 1'b1;
        @(negedge mclk);
        frame_end = 1'b0;
        @(negedge mclk);
        check({gain_stage1, gain_stage2, digital_gain}, {s1, s2, dg});
    endtask : fend

    // Expected loop filter step for one accepted pixel of weight w
    task automatic step(input logic [9:0] p, input logic [9:0] w);
        int wt;
        int d;
        wt  = (int'(p) * int'(w)) >> 7;
        wt  = (wt > 1023) ? 1023 : wt;
        d   = wt - int'(lvl);
        lvl = 10'(int'(lvl) + (d >>> 4));
    endtask : step

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_map;
        rdchk(elc_pkg::A_CTRL, 16'h0010);
        rdchk(elc_pkg::A_TARGET, 16'h60b8);
        rdchk(elc_pkg::A_RED, 16'h0080);
        rdchk(elc_pkg::A_GRN1, 16'h0080);
        rdchk(elc_pkg::A_GRN2, 16'h0080);
        rdchk(elc_pkg::A_BLUE, 16'h0080);
        rdchk(elc_pkg::A_SPARE, 16'h03ff);
        rdchk(8'ha7, 16'h0000);
        wr(elc_pkg::A_SPARE, 16'h0000);
        rdchk(elc_pkg::A_SPARE, 16'h03ff);
        wr(elc_pkg::A_RED, 16'hffff);
        rdchk(elc_pkg::A_RED, 16'h03ff);
        wr(elc_pkg::A_RED, 16'h0080);
        wr(elc_pkg::A_CTRL, 16'hffe0);
        rdchk(elc_pkg::A_CTRL, 16'h0000);
    endtask : t_reset_and_map

    task automatic t_restart_and_filter;
        wr(elc_pkg::A_TARGET, 16'h0200);
        wr(elc_pkg::A_CTRL, 16'h0013);
        @(negedge mclk);
        lvl = 10'h200;
        check(16'(filtered_level), 16'(lvl));
        wr(elc_pkg::A_CTRL, 16'h0011);
        pix(elc_pkg::COL_RED, 10'h100);
        step(10'h100, 10'h080);
        check(16'(filtered_level), 16'(lvl));
        wr(elc_pkg::A_CTRL, 16'h0010);
        pix(elc_pkg::COL_RED, 10'h000);
        check(16'(filtered_level), 16'(lvl));
        fend(2'h0, 2'h0, 12'h080);
    endtask : t_restart_and_filter

    task automatic t_gain_order;
        wr(elc_pkg::A_CTRL, 16'h0011);
        fend(2'h1, 2'h0, 12'h080);
        fend(2'h1, 2'h1, 12'h080);
        wr(elc_pkg::A_CTRL, 16'h0001);
        fend(2'h1, 2'h2, 12'h080);
        fend(2'h1, 2'h3, 12'h080);
        fend(2'h1, 2'h3, 12'h081);
        fend(2'h1, 2'h3, 12'h082);
        fend(2'h1, 2'h3, 12'h082);
        max_digital_gain = 12'h081;
        fend(2'h1, 2'h3, 12'h081);
    endtask : t_gain_order

    task automatic t_freeze;
        wr(elc_pkg::A_CTRL, 16'h0005);
        // Headroom so an unfrozen loop would raise the digital gain
        max_digital_gain = 12'h082;
        fend(2'h1, 2'h3, 12'h081);
        pix(elc_pkg::COL_RED, 10'h000);
        check(16'(filtered_level), 16'(lvl));
        wr(elc_pkg::A_CTRL, 16'h0001);
    endtask : t_freeze

    // Level above target with stage one preferred last: digital, then stage one, then two
    task automatic t_lower;
        wr(elc_pkg::A_TARGET, 16'h0000);
        fend(2'h1, 2'h3, 12'h080);
        fend(2'h0, 2'h3, 12'h080);
        fend(2'h0, 2'h2, 12'h080);
    endtask : t_lower

    task automatic t_green;
        wr(elc_pkg::A_GRN1, 16'h0100);
        wr(elc_pkg::A_GRN2, 16'h00c0);
        // Two greens on consecutive cycles
        pix_color = elc_pkg::COL_GRN1;
        pix_data  = 10'h180;
        pix_valid = 1'b1;
        @(negedge mclk);
        pix_color = elc_pkg::COL_GRN2;
        pix_data  = 10'h3ff;
        @(negedge mclk);
        pix_valid = 1'b0;
        step(10'h180, 10'h100);
        check(16'(filtered_level), 16'(lvl));
        @(negedge mclk);
        step(10'h3ff, 10'h0c0);
        check(16'(filtered_level), 16'(lvl));
    endtask : t_green

    task automatic t_subsample;
        wr(elc_pkg::A_BLUE, 16'h0040);
        wr(elc_pkg::A_CTRL, 16'h0009);
        for (int i = 0; i < 3; i++) begin
            pix(elc_pkg::COL_BLUE, 10'h3f0);
            check(16'(filtered_level), 16'(lvl));
        end
        pix(elc_pkg::COL_BLUE, 10'h010);
        step(10'h010, 10'h040);
        check(16'(filtered_level), 16'(lvl));
    endtask : t_subsample

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst             = 1'b0;
        reg_addr         = 8'h00;
        reg_wdata        = 16'h0000;
        reg_wr           = 1'b0;
        reg_rd           = 1'b0;
        pix_valid        = 1'b0;
        pix_color        = 2'h0;
        pix_data         = 10'h000;
        frame_end        = 1'b0;
        max_gain_stage1  = 2'h1;
        max_gain_stage2  = 2'h3;
        max_digital_gain = 12'h082;
        lvl              = 10'h0b8;
        n_errors         = 0;
        checks           = 0;
        repeat (12) @(negedge mclk);
        nrst = 1'b1;
        check({gain_stage1, gain_stage2, digital_gain}, 16'h0080);
        check(16'(filtered_level), 16'h00b8);
        t_reset_and_map();
        t_restart_and_filter();
        t_gain_order();
        t_freeze();
        t_lower();
        t_green();
        t_subsample();
        report_and_stop();
    end

    // Cuts a hang short well past the expected run of about 120 cycles
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
